/* rtl/lsc_pkg.sv */
// shared constants and types for the serial led sink control block
// assumes a 32-bit ahb-lite register bus and a 125 MHz system clock
package lsc_pkg;

    // channel structure
    localparam int CHANNELS = 16;
    localparam int CODE_W = 7;
    localparam int ONOFF_BITS = 16;
    localparam int DC_BITS = 112;

    // register byte offsets inside the 4 KiB window
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_ONOFF = 12'h008;
    localparam logic [5:0] ADDR_DC_PAGE = 6'h01; // 0x040..0x07c, one word per channel

    // control register fields and reset value
    localparam int CTRL_FORCE_OFF_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status register fields
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_BLANK_BIT = 1;
    localparam int STAT_DC_CNT_LSB = 8;
    localparam int STAT_ONOFF_CNT_LSB = 16;
    localparam int STAT_REFUSED_CNT_LSB = 24;

    // holding register reset values
    localparam logic [15:0] ONOFF_RESET = 16'h0000;
    localparam logic [111:0] DC_RESET = 112'h0;

    // turn-on stagger between neighbouring channels
    localparam int STEP_NS = 20;
    localparam int CLK_MHZ = 125;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;

    // ahb-lite encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } lsc_ahb_req_t;

endpackage

/* rtl/lsc_sync2.sv */
// two-stage level synchroniser, one bit per lane
// assumes inputs are levels that stay put for at least two clocks
`timescale 1ns/1ps
module lsc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule

/* rtl/lsc_delay_line.sv */
// fixed delay of a single bit by DEPTH clocks; zero depth is a plain wire
// assumes a free-running clock
`timescale 1ns/1ps
module lsc_delay_line #(
    parameter int DEPTH = 0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic d,
    output logic q
);
    generate
        if (DEPTH == 0) begin : g_wire
            assign q = d;
        end else begin : g_pipe
            logic [DEPTH-1:0] pipe;
            logic [DEPTH-1:0] next_pipe;

            // shift toward the top stage
            always_comb begin
                next_pipe = DEPTH'({pipe, d}); // the top stage drops out
            end

            // register the pipe
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pipe <= '0;
                end else begin
                    pipe <= next_pipe;
                end
            end

            assign q = pipe[DEPTH-1];
        end
    endgenerate
endmodule

/* rtl/lsc_core.sv */
// serial control of a 16-channel constant-current led sink with ahb-lite status/control
// assumes shiftClk idles while latch_pulse rises and while resetn is released
// assumes the shift data stand still for five system clocks after latch_pulse rises
// assumes latch_pulse stays high and low for at least three system clocks each
// limitation: serial_out shows a new mode's register only after its first shift edge
//
// How it works
// R1: each rising shift clock edge shifts serial_in into the register that mode selects.
// R2: a rising latch_pulse copies the selected shift register into the holding register.
// R3: every one of the 16 channels keeps its own 7-bit correction code, 128 steps.
// R4: the sink level of a lit channel equals its code, zero for 0 and full for 127.
// R5: correction data arrive as one 112-bit packet of sixteen 7-bit words, msb first.
// R6: with mode high the serial pins run the 112-bit correction shift register.
// R7: in correction mode a latch rising edge loads the correction register.
// R8: blank high forces every output off; blank low lets on/off and correction act.
// R9: on/off data arrive as a 16-bit packet, one bit per channel, msb first.
// R10: with mode low the serial pins run the 16-bit on/off shift register.
// R11: an on/off latch edge takes effect only while blank is high.
// R12: channel n switches n fixed delay steps after channel 0.
// R13: serial_out feeds the next device's serial_in so devices chain.
// R14: serial_out shows the bit leaving the selected shift register at each edge.
// R15: the top channel's word goes first, so channel 0 ends in the lowest bits.
`timescale 1ns/1ps
module lsc_core
    import lsc_pkg::*;
#(
    parameter int NCH = CHANNELS,
    parameter int CW = CODE_W,
    parameter int STEP = STEP_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link; serial_in, mode and serial_out are clocked by the controller's shift clock, latch_pulse and blank are not
    input wire logic shiftClk,
    input wire logic serial_in,
    input wire logic mode,
    input wire logic latch_pulse,
    input wire logic blank,
    output logic serial_out,
    // channel drive
    output logic [NCH-1:0] chanOn,
    output logic [NCH*CW-1:0] sinkLevel
);
    // width of the packed correction data
    localparam int DCW = NCH * CW;

    // link domain: everything here runs on the controller's shift clock
    // serial_in and mode are timed to that clock, so they need no synchroniser
    logic [NCH-1:0] onShift;
    logic [DCW-1:0] dcShift;
    logic [NCH-1:0] next_onShift;
    logic [DCW-1:0] next_dcShift;
    logic next_serialOut;

    // serial_out takes the top bit as it stands after the shift, so the next
    // device in a chain samples the oldest bit at its following edge
    // mode steers the shift; the other register holds still
    always_comb begin
        next_onShift = onShift;
        next_dcShift = dcShift;
        next_serialOut = serial_out;
        if (mode) begin
            next_dcShift = {dcShift[DCW-2:0], serial_in}; // [R1] [R5] [R6] [R15]
            next_serialOut = dcShift[DCW-2]; // [R14] [R13]
        end else begin
            next_onShift = {onShift[NCH-2:0], serial_in}; // [R1] [R9] [R10] [R15]
            next_serialOut = onShift[NCH-2]; // [R14] [R13]
        end
    end

    // shift registers and serial output
    always_ff @(posedge shiftClk or negedge resetn) begin
        if (!resetn) begin
            onShift <= '0;
            dcShift <= '0;
            serial_out <= 1'b0;
        end else begin
            onShift <= next_onShift;
            dcShift <= next_dcShift;
            serial_out <= next_serialOut;
        end
    end

    // pin synchronisers: latch and blank come from another clock
    // mode is synchronised as well, for the latch decision and the status word
    // a 3-bit lane keeps the three pins in one instance
    logic [2:0] pinSync;
    logic latchSync;
    logic modeSync;
    logic blankSync;
    logic latchPrev;
    logic latchRise;

    lsc_sync2 #(
        .W(3)
    ) u_sync (
        .clk(clk_sys),
        .resetn(resetn),
        .d({latch_pulse, mode, blank}),
        .q(pinSync)
    );

    // name the synchronised lanes; a rising latch is one clock wide
    assign latchSync = pinSync[2];
    assign modeSync = pinSync[1];
    assign blankSync = pinSync[0];
    assign latchRise = latchSync & ~latchPrev;

    // holding registers and latch counters on the system clock
    // the shift registers cross unsynchronised: they stand still once the frame
    // has ended, and the synchronised latch edge comes two or three clocks later
    // a latch while blank is low leaves the on/off bits alone and is counted
    logic [NCH-1:0] onHold;
    logic [DCW-1:0] dcHold;
    logic [7:0] dcCount;
    logic [7:0] onCount;
    logic [7:0] refusedCount;
    logic [NCH-1:0] next_onHold;
    logic [DCW-1:0] next_dcHold;
    logic [7:0] next_dcCount;
    logic [7:0] next_onCount;
    logic [7:0] next_refusedCount;

    // latch edge: shift data are quiet, so they cross as a stable word
    always_comb begin
        next_onHold = onHold;
        next_dcHold = dcHold;
        next_dcCount = dcCount;
        next_onCount = onCount;
        next_refusedCount = refusedCount;
        if (latchRise) begin
            if (modeSync) begin
                next_dcHold = dcShift; // [R2] [R3] [R7]
                next_dcCount = dcCount + 8'h01;
            end else if (blankSync) begin
                next_onHold = onShift; // [R2] [R11]
                next_onCount = onCount + 8'h01;
            end else begin
                next_refusedCount = refusedCount + 8'h01; // [R11]
            end
        end
    end

    // register holding state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latchPrev <= 1'b0;
            onHold <= ONOFF_RESET;
            dcHold <= DC_RESET;
            dcCount <= 8'h00;
            onCount <= 8'h00;
            refusedCount <= 8'h00;
        end else begin
            latchPrev <= latchSync;
            onHold <= next_onHold;
            dcHold <= next_dcHold;
            dcCount <= next_dcCount;
            onCount <= next_onCount;
            refusedCount <= next_refusedCount;
        end
    end

    // channel drive: blank, force-off and the on bits gate each channel
    // the stagger spreads turn-on so the supply sees one channel at a time
    // sinkLevel carries the code only while the channel is lit
    logic forceOff;
    logic [NCH-1:0] enableRaw;
    logic [NCH-1:0] enableLate;
    logic [NCH-1:0] next_chanOn;
    logic [NCH*CW-1:0] next_sinkLevel;

    // blank and the software force both switch all channels off
    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            enableRaw[n] = onHold[n] & ~blankSync & ~forceOff; // [R8]
        end
    end

    // channel n waits n delay steps
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_stagger
            lsc_delay_line #(
                .DEPTH(gi * STEP)
            ) u_delay (
                .clk(clk_sys),
                .resetn(resetn),
                .d(enableRaw[gi]),
                .q(enableLate[gi]) // [R12]
            );
        end
    endgenerate

    // sink level is the code of a lit channel, else zero
    always_comb begin
        next_chanOn = enableLate;
        for (int n = 0; n < NCH; n++) begin
            next_sinkLevel[n*CW +: CW] = enableLate[n] ? dcHold[n*CW +: CW] : '0; // [R4]
        end
    end

    // register the drive outputs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chanOn <= '0;
            sinkLevel <= '0;
        end else begin
            chanOn <= next_chanOn;
            sinkLevel <= next_sinkLevel;
        end
    end

    // register bus slave, zero wait states
    // 0x000 control: bit 0 forces every channel off
    // 0x004 status: mode, blank and three 8-bit latch counters
    // 0x008 on/off holding bits, read only
    // 0x040 + 4n: correction code of channel n, read only
    // other reads return zero; a non-word or out-of-window access does nothing
    lsc_ahb_req_t req;
    lsc_ahb_req_t next_req;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] next_hrdata;
    logic accept;
    logic ctrlWrite;
    logic [31:0] ctrlView;
    logic [11:0] rdAddr;
    logic [31:0] status;

    // transfer accepted, control write in its data phase, force-off bit
    assign accept = hsel & htrans[1] & hready;
    assign ctrlWrite = req.valid & req.write & (req.addr == ADDR_CTRL);
    assign forceOff = ctrl[CTRL_FORCE_OFF_BIT];
    assign rdAddr = haddr[11:0];

    // a read right behind a control write sees the new value
    assign ctrlView = ctrlWrite ? {31'h0, hwdata[CTRL_FORCE_OFF_BIT]} : ctrl;

    // status word
    always_comb begin
        status = 32'h0;
        status[STAT_MODE_BIT] = modeSync;
        status[STAT_BLANK_BIT] = blankSync;
        status[STAT_DC_CNT_LSB +: 8] = dcCount;
        status[STAT_ONOFF_CNT_LSB +: 8] = onCount;
        status[STAT_REFUSED_CNT_LSB +: 8] = refusedCount;
    end

    // address phase capture, write in data phase, read data prepared at address phase
    always_comb begin
        next_req = '0;
        next_ctrl = ctrl;
        next_hrdata = hrdata;
        if (ctrlWrite) begin
            next_ctrl = {31'h0, hwdata[CTRL_FORCE_OFF_BIT]};
        end
        if (accept) begin
            next_req.valid = (hsize == HSIZE_WORD) && (haddr[31:12] == 20'h0);
            next_req.write = hwrite;
            next_req.addr = rdAddr;
            next_hrdata = 32'h0;
            // only a word read inside the window returns data
            if (!hwrite && next_req.valid) begin
                if (rdAddr == ADDR_CTRL) begin
                    next_hrdata = ctrlView;
                end else if (rdAddr == ADDR_STATUS) begin
                    next_hrdata = status;
                end else if (rdAddr == ADDR_ONOFF) begin
                    next_hrdata = {{(32-NCH){1'b0}}, onHold};
                end else if (rdAddr[11:6] == ADDR_DC_PAGE && rdAddr[1:0] == 2'h0) begin
                    next_hrdata = {{(32-CW){1'b0}}, dcHold[rdAddr[5:2]*CW +: CW]}; // [R3]
                end
            end
        end
    end

    // register bus state; zero wait states, always okay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            req <= '0;
            ctrl <= CTRL_RESET;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            req <= next_req;
            ctrl <= next_ctrl;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

/* tb/lsc_monitor.sv */
// port assertions for the serial led sink control block
// assumes a bind into lsc_core from the bench top
`timescale 1ns/1ps
module lsc_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic shiftClk,
    input wire logic serial_in,
    input wire logic mode,
    input wire logic latch_pulse,
    input wire logic blank,
    input wire logic serial_out,
    input wire logic [15:0] chanOn,
    input wire logic [111:0] sinkLevel
);
    logic [7:0] run;
    logic prevMode;
    logic [7:0] sinceLatch;
    logic [7:0] sinceEvt;
    logic [7:0] blankRun;
    logic [111:0] litMask;
    // length of the current run of shift edges in one mode
    always_ff @(posedge shiftClk or negedge resetn) begin
        if (!resetn) begin
            run <= '0;
            prevMode <= 1'b0;
        end else begin
            prevMode <= mode;
            run <= (mode != prevMode) ? 8'h01 : run + {7'h0, run != 8'hff};
        end
    end
    // cycles since a latch rise, since any cause of a drive change, and of blank high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sinceLatch <= 8'hff;
            sinceEvt <= 8'hff;
            blankRun <= '0;
        end else begin
            sinceLatch <= $rose(latch_pulse) ? '0 : sinceLatch + {7'h0, sinceLatch != 8'hff};
            sinceEvt <= ($rose(latch_pulse) || $changed(blank) || (hsel && htrans[1] && hwrite))
                ? '0 : sinceEvt + {7'h0, sinceEvt != 8'hff};
            blankRun <= blank ? blankRun + {7'h0, blankRun != 8'hff} : '0;
        end
    end
    // level bits of each channel enabled by its on flag
    always_comb begin
        for (int i = 0; i < 112; i++) litMask[i] = chanOn[i / 7];
    end
    onoff_chain_a: assert property (@(posedge shiftClk) disable iff (!resetn)
        (!mode && !prevMode && run >= 8'd16) |-> serial_out == $past(serial_in, 16))
        else $error("serial out is not the bit taken 16 edges earlier");
    dc_chain_a: assert property (@(posedge shiftClk) disable iff (!resetn)
        (mode && prevMode && run >= 8'd112) |-> serial_out == $past(serial_in, 112))
        else $error("serial out is not the bit taken 112 edges earlier");
    blank_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        blankRun >= 8'd60 |-> chanOn == '0)
        else $error("channel lit while blank held high");
    blank_quick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(blank) |-> ##[1:8] !chanOn[0])
        else $error("channel 0 not off soon after blank");
    off_level_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sinkLevel & ~litMask) == '0)
        else $error("level on a channel that is off");
    level_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($stable(chanOn) && !$stable(sinkLevel)) |-> sinceLatch < 8'd64)
        else $error("level changed with no latch");
    on_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$stable(chanOn) |-> sinceEvt < 8'd64)
        else $error("channel switched with no cause");
    bus_okay_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule

/* tb/lsc_ctrl_model.sv */
// controller model driving the serial link of the led sink block
// assumes the bench calls send and latch one at a time
`timescale 1ns/1ps
module lsc_ctrl_model (
    output logic shiftClk,
    output logic serial_in,
    output logic mode,
    output logic latch_pulse,
    input wire logic serial_out,
    output logic [111:0] seen
);
    // link idle at time zero
    initial begin
        shiftClk = 1'b0;
        serial_in = 1'b0;
        mode = 1'b0;
        latch_pulse = 1'b0;
        seen = '0;
    end
    // one frame at 12 ns, top word and msb first; clock stands still outside it
    task automatic send(input logic m, input logic [111:0] v, input int n);
        mode = m;
        #5.3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            // take serial_out as a chained device would, just before the rise
            #6 seen = {seen[110:0], serial_out};
            shiftClk = 1'b1;
            #6 shiftClk = 1'b0;
        end
        serial_in = ~serial_in;
        #5;
    endtask
    // latch pulse long enough for the system clock, mode held past it
    task automatic latch();
        latch_pulse = 1'b1;
        #40 latch_pulse = 1'b0;
        #40;
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the serial led sink control block
// assumes lsc_core, lsc_monitor and the controller model
`timescale 1ns/1ps
module tb_top
    import lsc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = '0;
    logic blank = 1'b1;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, shiftClk, serial_in, mode, latch_pulse, serial_out;
    logic [15:0] chanOn, onv;
    logic [111:0] sinkLevel, seen, dc;
    int n_fail = 0;
    int n_tests = 0;
    int seed = 38;
    int first [16];

    always #4 clk_sys = ~clk_sys;

    lsc_core DUT (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .shiftClk(shiftClk), .serial_in(serial_in), .mode(mode),
        .latch_pulse(latch_pulse), .blank(blank), .serial_out(serial_out),
        .chanOn(chanOn), .sinkLevel(sinkLevel));
    lsc_ctrl_model ctl (.shiftClk(shiftClk), .serial_in(serial_in), .mode(mode),
        .latch_pulse(latch_pulse), .serial_out(serial_out), .seen(seen));

    // compare and count
    task automatic check(input logic [111:0] got, input logic [111:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single ahb-lite transfer, read data kept in rd
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            @(posedge clk_sys);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = hrdata;
    endtask
    // expected levels: code of each lit channel, zero elsewhere
    function automatic logic [111:0] lvl(input logic [15:0] on, input logic [111:0] c);
        for (int i = 0; i < 112; i++) begin
            lvl[i] = on[i / 7] & c[i];
        end
    endfunction
    // print counts and verdict, then stop
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(1'b0, ADDR_CTRL, '0);
        check(112'(rd), 112'(CTRL_RESET));
        bus(1'b0, 12'h100, '0);
        check(112'(rd), '0);
        check(sinkLevel, DC_RESET);
        $display("test reset done");
        // random codes with zero and full scale at the ends
        dc = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
        dc[111:105] = 7'h7f;
        dc[6:0] = 7'h00;
        ctl.send(1'b1, dc, DC_BITS);
        ctl.latch();
        check(seen, '0);
        for (int n = 0; n < CHANNELS; n++) begin
            bus(1'b0, {ADDR_DC_PAGE, 6'(4 * n)}, '0);
            check(112'(rd), 112'(dc[7*n+:7]));
        end
        $display("test correction done");
        onv = 16'($random(seed));
        ctl.send(1'b0, 112'(onv), ONOFF_BITS);
        ctl.latch();
        bus(1'b0, ADDR_ONOFF, '0);
        check(112'(rd), 112'(onv));
        blank <= 1'b0;
        repeat (60) @(posedge clk_sys);
        check(112'(chanOn), 112'(onv));
        check(sinkLevel, lvl(onv, dc));
        ctl.send(1'b0, 112'(~onv), ONOFF_BITS);
        ctl.latch();
        check(112'(seen[15:0]), 112'(onv));
        bus(1'b0, ADDR_ONOFF, '0);
        check(112'(rd), 112'(onv));
        $display("test on/off done");
        blank <= 1'b1;
        ctl.send(1'b0, 112'(16'hffff), ONOFF_BITS);
        ctl.latch();
        repeat (60) @(posedge clk_sys);
        check(112'(chanOn), '0);
        blank <= 1'b0;
        for (int n = 0; n < 16; n++) first[n] = -1;
        for (int c = 0; c < 80; c++) begin
            @(posedge clk_sys);
            for (int n = 0; n < 16; n++) begin
                if (chanOn[n] === 1'b1 && first[n] < 0) first[n] = c;
            end
        end
        for (int n = 0; n < 16; n++) begin
            check(112'(first[n] - first[0]), 112'(n * STEP_CYC));
        end
        $display("test stagger done");
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (60) @(posedge clk_sys);
        check(112'(chanOn), '0);
        bus(1'b1, ADDR_CTRL, 32'h0);
        ctl.send(1'b1, ~dc, DC_BITS);
        ctl.latch();
        check(seen, dc);
        repeat (60) @(posedge clk_sys);
        check(sinkLevel, lvl(16'hffff, ~dc));
        bus(1'b0, ADDR_STATUS, '0);
        check(112'(rd), 112'(32'h0102_0201));
        // a third correction frame pushes the held one out unchanged
        ctl.send(1'b1, dc, DC_BITS);
        check(seen, ~dc);
        $display("test reload done");
        conclude();
    end
endmodule

bind lsc_core lsc_monitor mon (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
    .shiftClk(shiftClk), .serial_in(serial_in), .mode(mode), .latch_pulse(latch_pulse),
    .blank(blank), .serial_out(serial_out), .chanOn(chanOn), .sinkLevel(sinkLevel));
